// file: include/ckg_pkg.sv
// ==================================================================
// clock generator control: shared constants
package ckg_pkg;
  // ================================================================
  // register map (byte addresses on the apb bus)
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_PROTECT = 8'h00;
  localparam logic [7:0] ADDR_OSC_EN = 8'h04;
  localparam logic [7:0] ADDR_LS_CFG = 8'h08;
  localparam logic [7:0] ADDR_HS_CFG = 8'h0c;
  localparam logic [7:0] ADDR_TRIM = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM_CLK = 8'h14;
  localparam logic [7:0] ADDR_CLKOUT = 8'h18;
  localparam logic [7:0] ADDR_IOSC_CTL = 8'h1c;
  localparam logic [7:0] ADDR_FLAGS = 8'h20;
  localparam logic [7:0] ADDR_ENABLES = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h28;
  localparam logic [15:0] PROTECT_UNLOCK = 16'h0096;
  // ================================================================
  // oscillator indices and osc enable register layout
  localparam int OSC_INT = 0;
  localparam int OSC_LS = 1;
  localparam int OSC_HS = 2;
  localparam int OSC_EXT = 3;
  localparam int SLP_STOP_LSB = 8;
  localparam logic [31:0] OSC_EN_MASK = 32'h0000_0f0f;
  localparam logic [31:0] OSC_EN_RST = 32'h0000_0f01;
  // ================================================================
  // low-speed config fields
  localparam int LS_TYPE_BIT = 0;
  localparam int LS_WAIT_LSB = 4;
  localparam int LS_RESTART_BIT = 24;
  localparam int LS_DETECT_BIT = 25;
  localparam logic [31:0] LS_CFG_MASK = 32'h0313_7331;
  // high-speed config and trim fields
  localparam int HS_WAIT_LSB = 4;
  localparam logic [31:0] HS_CFG_MASK = 32'h0000_7373;
  localparam logic [4:0] HS_TRIM_RST = 5'h00;
  // system clock config fields
  localparam int SRC_LSB = 0;
  localparam int DIV_LSB = 4;
  localparam int WAKE_SRC_LSB = 8;
  localparam int WAKE_DIV_LSB = 12;
  localparam int WAKE_MODE_BIT = 15;
  localparam logic [31:0] SYSTEM_CLK_MASK = 32'h0000_b333;
  localparam logic [31:0] SYSTEM_CLK_RST = 32'h0000_0000;
  localparam logic [1:0] SRC_INTERNAL = 2'h0;
  // clock output config fields
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_SRC_LSB = 4;
  localparam int OUT_DIV_LSB = 8;
  localparam logic [31:0] CLKOUT_MASK = 32'h0000_0731;
  // ================================================================
  // event flag bits
  localparam int FLG_INT_STABLE = 0;
  localparam int FLG_LS_STABLE = 1;
  localparam int FLG_HS_STABLE = 2;
  localparam int FLG_TRIM_DONE = 4;
  localparam int FLG_LS_STOP = 5;
  localparam logic [5:0] FLAGS_MASK = 6'h37;
  // status register fields
  localparam int ST_READY_LSB = 8;
  localparam int ST_SLEEP_BIT = 12;
  localparam int ST_TRIM_BIT = 13;
  // ================================================================
  // stabilization waits, in oscillator edges
  localparam logic [16:0] INT_WAIT_CYC = 17'h00010;
  localparam logic [16:0] LS_WAIT_BASE = 17'h00100;
  localparam logic [16:0] HS_WAIT_BASE = 17'h00008;
  // stop detection timeout, least time
  localparam int CLK_PERIOD_NS = 40;
  localparam int STOP_TIMEOUT_NS = 100000;
  localparam logic [11:0] STOP_TIMEOUT_CYC =
    12'((STOP_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [5:0] TRIM_CENTER = 6'h20;
  typedef enum logic {TRIM_IDLE, TRIM_RUN} ckg_trim_t;
endpackage : ckg_pkg

// file: verilog/ckg_tick_div.sv
`timescale 1ns/1ps
// ==================================================================
// divides a stream of source ticks by 2^divSel
module ckg_tick_div #(
  parameter int CW = 7
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tickIn,
  input wire logic enable,
  input wire logic [2:0] divSel,
  output logic tickOut,
  output logic levelOut
);
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] lastCnt;
  logic tick_r, tick_nxt;
  logic level_r, level_nxt;

  assign lastCnt = CW'((8'h01 << divSel) - 8'h01);
  assign tickOut = tick_r;
  assign levelOut = level_r;

  // count ticks, emit one pulse and a toggle per wrap
  always_comb begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    level_nxt = level_r;
    if (!enable) begin
      cnt_nxt = '0;
      level_nxt = 1'b0; // output parked low while disabled
    end else if (tickIn) begin
      if (cnt_r >= lastCnt) begin
        cnt_nxt = '0;
        tick_nxt = 1'b1;
        level_nxt = ~level_r;
      end else begin
        cnt_nxt = cnt_r + CW'(1);
      end
    end
  end

  // state registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
      level_r <= level_nxt;
    end
  end
endmodule : ckg_tick_div

// file: verilog/ckg_clock_ctrl.sv
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ps
// ==================================================================
// clock generator control with apb registers
// Functional notes
// - key 0x0096 unlocks, other values relock
// - low-speed stable flag after configured wait
// - high-speed stable flag after configured wait
// - reset runs system from internal oscillator
// - system clock register writable only unlocked
// - per-source sleep stop bits on sleep
// - wake mode applies wake source and divider
// - clock out: source, divider, only when enabled
// - trim done clears start bit, sets flag
// - stop sets flag, optional low-speed restart
// - flags write-one-clear, irq when enabled
// - enable bit falling also sets stop flag
// - internal wait 16 edges gates supply
module ckg_clock_ctrl #(
  parameter int TRIM_REF_EDGES = 1024
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ckg_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic internalClkIn,
  input wire logic lowspeedClkIn,
  input wire logic highspeedClkIn,
  input wire logic extClkIn,
  input wire logic sleepReq,
  output logic internalOscOn,
  output logic lowspeedOscOn,
  output logic highspeedOscOn,
  output logic extClkOn,
  output logic [2:0] clockSupplyOn,
  output logic [31:0] lowspeedCfg,
  output logic [31:0] highspeedCfg,
  output logic [4:0] highspeedTrim,
  output logic [5:0] internalTrimCode,
  output logic [1:0] sysclkSource,
  output logic [1:0] sysclkDivider,
  output logic sysclkTick,
  output logic clockOutPin,
  output logic clockIrq
);
  import ckg_pkg::*;

  // ================================================================
  // helpers
  function automatic logic [16:0] waitTarget(input int idx, input logic [1:0] lsw,
                                             input logic [2:0] hsw);
    logic [16:0] t;
    t = INT_WAIT_CYC;
    if (idx == OSC_LS) t = LS_WAIT_BASE << {lsw, 1'b0};
    if (idx == OSC_HS) t = HS_WAIT_BASE << hsw;
    return t;
  endfunction : waitTarget

  function automatic logic selTick(input logic [1:0] src, input logic [3:0] edg,
                                   input logic [3:0] live);
    return edg[src] & live[src];
  endfunction : selTick

  // ================================================================
  // state
  logic [15:0] protKey_r, protKey_nxt;
  logic [31:0] oscEnReg_r, oscEnReg_nxt, lsCfg_r, lsCfg_nxt, hsCfg_r, hsCfg_nxt;
  logic [31:0] sysCfg_r, sysCfg_nxt, outCfg_r, outCfg_nxt;
  logic [4:0] trimReg_r, trimReg_nxt;
  logic trimStart_r, trimStart_nxt, sleepPrev_r;
  logic [5:0] flags_r, flags_nxt, irqEn_r, irqEn_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt, irq_nxt;
  logic [3:0] syncA_r, syncB_r, syncC_r, edges, live;
  logic [3:0] oscOn_r, oscOn_nxt;
  logic [2:0] ready_r, ready_nxt, stableEv;
  logic [16:0] waitCnt_r [3], waitCnt_nxt [3];
  logic lsRestart_r, lsRestart_nxt, stopEv, trimDoneEv;
  logic [11:0] stopCnt_r, stopCnt_nxt;
  ckg_trim_t trimState_r, trimState_nxt;
  logic [15:0] refCnt_r, refCnt_nxt, intCnt_r, intCnt_nxt;
  logic [5:0] trimCode_r, trimCode_nxt;
  logic [1:0] appSrc_r, appSrc_nxt, appDiv_r, appDiv_nxt;
  logic unlocked, wrCommit, wakeApply, sysTick;

  assign unlocked = (protKey_r == PROTECT_UNLOCK);
  assign edges = syncB_r & ~syncC_r;
  assign live = {oscOn_r[OSC_EXT], ready_r};
  assign wrCommit = psel & penable & pready_r & pwrite;
  assign wakeApply = sleepPrev_r & ~sleepReq & sysCfg_r[WAKE_MODE_BIT];

  // outputs straight from flip-flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign {extClkOn, highspeedOscOn, lowspeedOscOn, internalOscOn} = oscOn_r;
  assign clockSupplyOn = ready_r;
  assign lowspeedCfg = lsCfg_r;
  assign highspeedCfg = hsCfg_r;
  assign highspeedTrim = trimReg_r;
  assign internalTrimCode = trimCode_r;
  assign sysclkSource = appSrc_r;
  assign sysclkDivider = appDiv_r;

  // ================================================================
  // registers and apb slave: one wait state, write at the pready edge
  always_comb begin
    protKey_nxt = protKey_r;
    oscEnReg_nxt = oscEnReg_r;
    lsCfg_nxt = lsCfg_r;
    hsCfg_nxt = hsCfg_r;
    sysCfg_nxt = sysCfg_r;
    outCfg_nxt = outCfg_r;
    trimReg_nxt = trimReg_r;
    trimStart_nxt = trimStart_r;
    irqEn_nxt = irqEn_r;
    flags_nxt = flags_r;
    pready_nxt = psel & penable & ~pready_r;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    if (pready_nxt) begin
      case (paddr)
        ADDR_PROTECT: prdata_nxt = {16'h0000, protKey_r};
        ADDR_OSC_EN: prdata_nxt = oscEnReg_r;
        ADDR_LS_CFG: prdata_nxt = lsCfg_r;
        ADDR_HS_CFG: prdata_nxt = hsCfg_r;
        ADDR_TRIM: prdata_nxt = {27'h0, trimReg_r};
        ADDR_SYSTEM_CLK: prdata_nxt = sysCfg_r;
        ADDR_CLKOUT: prdata_nxt = outCfg_r;
        ADDR_IOSC_CTL: prdata_nxt = {31'h0, trimStart_r};
        ADDR_FLAGS: prdata_nxt = {26'h0, flags_r};
        ADDR_ENABLES: prdata_nxt = {26'h0, irqEn_r};
        ADDR_STATUS: begin
          prdata_nxt[SRC_LSB +: 2] = appSrc_r;
          prdata_nxt[DIV_LSB +: 2] = appDiv_r;
          prdata_nxt[ST_READY_LSB +: 4] = live;
          prdata_nxt[ST_SLEEP_BIT] = sleepReq;
          prdata_nxt[ST_TRIM_BIT] = (trimState_r == TRIM_RUN);
        end
        default: pslverr_nxt = 1'b1; // unmapped address
      endcase
    end
    if (wrCommit) begin
      case (paddr)
        ADDR_PROTECT: protKey_nxt = pwdata[15:0];
        ADDR_OSC_EN: begin
          oscEnReg_nxt[3:0] = pwdata[3:0];
          if (unlocked) oscEnReg_nxt = pwdata & OSC_EN_MASK;
        end
        ADDR_LS_CFG: if (unlocked) lsCfg_nxt = pwdata & LS_CFG_MASK;
        ADDR_HS_CFG: if (unlocked) hsCfg_nxt = pwdata & HS_CFG_MASK;
        ADDR_TRIM: if (unlocked) trimReg_nxt = pwdata[4:0];
        ADDR_SYSTEM_CLK: if (unlocked) sysCfg_nxt = pwdata & SYSTEM_CLK_MASK;
        ADDR_CLKOUT: outCfg_nxt = pwdata & CLKOUT_MASK;
        ADDR_IOSC_CTL: if (unlocked) trimStart_nxt = pwdata[0];
        ADDR_FLAGS: flags_nxt = flags_r & ~pwdata[5:0];
        ADDR_ENABLES: irqEn_nxt = pwdata[5:0] & FLAGS_MASK;
        default: ;
      endcase
    end
    // wake setting becomes the system clock setting
    if (wakeApply) begin
      sysCfg_nxt[SRC_LSB +: 2] = sysCfg_r[WAKE_SRC_LSB +: 2];
      sysCfg_nxt[DIV_LSB +: 2] = sysCfg_r[WAKE_DIV_LSB +: 2];
    end
    if (trimDoneEv) trimStart_nxt = 1'b0;
    // hardware events win over a same-cycle clear
    flags_nxt[FLG_INT_STABLE] = flags_nxt[FLG_INT_STABLE] | stableEv[OSC_INT];
    flags_nxt[FLG_LS_STABLE] = flags_nxt[FLG_LS_STABLE] | stableEv[OSC_LS];
    flags_nxt[FLG_HS_STABLE] = flags_nxt[FLG_HS_STABLE] | stableEv[OSC_HS];
    flags_nxt[FLG_TRIM_DONE] = flags_nxt[FLG_TRIM_DONE] | trimDoneEv;
    flags_nxt[FLG_LS_STOP] = flags_nxt[FLG_LS_STOP] | stopEv
      | (oscEnReg_r[OSC_LS] & ~oscEnReg_nxt[OSC_LS])
      | (lsCfg_r[LS_DETECT_BIT] & ~lsCfg_nxt[LS_DETECT_BIT]);
    irq_nxt = |(flags_r & irqEn_r);
  end

  // register file flops
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      protKey_r <= 16'h0000;
      oscEnReg_r <= OSC_EN_RST;
      lsCfg_r <= 32'h0000_0000;
      hsCfg_r <= 32'h0000_0000;
      sysCfg_r <= SYSTEM_CLK_RST;
      outCfg_r <= 32'h0000_0000;
      trimReg_r <= HS_TRIM_RST;
      trimStart_r <= 1'b0;
      flags_r <= 6'h00;
      irqEn_r <= 6'h00;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      clockIrq <= 1'b0;
      sleepPrev_r <= 1'b0;
    end else begin
      protKey_r <= protKey_nxt;
      oscEnReg_r <= oscEnReg_nxt;
      lsCfg_r <= lsCfg_nxt;
      hsCfg_r <= hsCfg_nxt;
      sysCfg_r <= sysCfg_nxt;
      outCfg_r <= outCfg_nxt;
      trimReg_r <= trimReg_nxt;
      trimStart_r <= trimStart_nxt;
      flags_r <= flags_nxt;
      irqEn_r <= irqEn_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      clockIrq <= irq_nxt;
      sleepPrev_r <= sleepReq;
    end
  end

  // ================================================================
  // oscillator sequencing, stop detection, trimming, source switch
  always_comb begin
    oscOn_nxt = oscEnReg_r[3:0] & ~({4{sleepReq}} & oscEnReg_r[SLP_STOP_LSB +: 4]);
    oscOn_nxt[OSC_LS] = oscOn_nxt[OSC_LS] & ~lsRestart_r;
    ready_nxt = ready_r;
    stableEv = 3'h0;
    for (int i = 0; i < 3; i++) begin
      waitCnt_nxt[i] = waitCnt_r[i];
      if (!oscOn_r[i]) begin
        ready_nxt[i] = 1'b0;
        waitCnt_nxt[i] = '0;
      end else if (!ready_r[i] && edges[i]) begin
        waitCnt_nxt[i] = waitCnt_r[i] + 17'h1;
        if (waitCnt_nxt[i] >= waitTarget(i, lsCfg_r[LS_WAIT_LSB +: 2],
                                         hsCfg_r[HS_WAIT_LSB +: 3])) begin
          ready_nxt[i] = 1'b1;
          stableEv[i] = 1'b1;
        end
      end
    end
    // stop detection: no low-speed edge for the timeout
    stopEv = 1'b0;
    lsRestart_nxt = 1'b0;
    stopCnt_nxt = 12'h000;
    if (lsCfg_r[LS_DETECT_BIT] && ready_r[OSC_LS] && !edges[OSC_LS]) begin
      stopCnt_nxt = stopCnt_r;
      if (stopCnt_r < STOP_TIMEOUT_CYC) stopCnt_nxt = stopCnt_r + 12'h001;
      if (stopCnt_r == STOP_TIMEOUT_CYC - 12'h001) begin
        stopEv = 1'b1;
        lsRestart_nxt = lsCfg_r[LS_RESTART_BIT];
      end
    end
    // auto-trim: count internal edges over a low-speed window
    trimState_nxt = trimState_r;
    refCnt_nxt = refCnt_r;
    intCnt_nxt = intCnt_r;
    trimCode_nxt = trimCode_r;
    trimDoneEv = 1'b0;
    case (trimState_r)
      TRIM_IDLE: begin
        refCnt_nxt = 16'h0000;
        intCnt_nxt = 16'h0000;
        if (trimStart_r) trimState_nxt = TRIM_RUN;
      end
      TRIM_RUN: begin
        if (!trimStart_r) trimState_nxt = TRIM_IDLE; // aborted by software
        else begin
          if (edges[OSC_INT]) intCnt_nxt = intCnt_r + 16'h0001;
          if (edges[OSC_LS]) refCnt_nxt = refCnt_r + 16'h0001;
          if (edges[OSC_LS] && refCnt_r == 16'(TRIM_REF_EDGES - 1)) begin
            trimCode_nxt = TRIM_CENTER + 6'(refCnt_nxt - intCnt_nxt);
            trimDoneEv = 1'b1;
            trimState_nxt = TRIM_IDLE;
          end
        end
      end
      default: trimState_nxt = TRIM_IDLE;
    endcase
    // take a new selection only at a tick, or if current source is dead
    appSrc_nxt = appSrc_r;
    appDiv_nxt = appDiv_r;
    if (sysTick || !live[appSrc_r]) begin
      appSrc_nxt = sysCfg_r[SRC_LSB +: 2];
      appDiv_nxt = sysCfg_r[DIV_LSB +: 2];
    end
  end

  // oscillator flops and pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      syncA_r <= 4'h0;
      syncB_r <= 4'h0;
      syncC_r <= 4'h0;
      oscOn_r <= 4'h0;
      ready_r <= 3'h0;
      for (int i = 0; i < 3; i++) waitCnt_r[i] <= '0;
      lsRestart_r <= 1'b0;
      stopCnt_r <= 12'h000;
      trimState_r <= TRIM_IDLE;
      refCnt_r <= 16'h0000;
      intCnt_r <= 16'h0000;
      trimCode_r <= TRIM_CENTER;
      appSrc_r <= SRC_INTERNAL;
      appDiv_r <= 2'h0;
    end else begin
      syncA_r <= {extClkIn, highspeedClkIn, lowspeedClkIn, internalClkIn};
      syncB_r <= syncA_r;
      syncC_r <= syncB_r;
      oscOn_r <= oscOn_nxt;
      ready_r <= ready_nxt;
      for (int i = 0; i < 3; i++) waitCnt_r[i] <= waitCnt_nxt[i];
      lsRestart_r <= lsRestart_nxt;
      stopCnt_r <= stopCnt_nxt;
      trimState_r <= trimState_nxt;
      refCnt_r <= refCnt_nxt;
      intCnt_r <= intCnt_nxt;
      trimCode_r <= trimCode_nxt;
      appSrc_r <= appSrc_nxt;
      appDiv_r <= appDiv_nxt;
    end
  end

  // ================================================================
  // system clock tick and external clock output dividers
  ckg_tick_div u_sys_div (
    .clk(clk),
    .rst_n(rst_n),
    .tickIn(selTick(appSrc_r, edges, live)),
    .enable(~sleepReq),
    .divSel({1'b0, appDiv_r}),
    .tickOut(sysTick),
    .levelOut()
  );

  ckg_tick_div u_out_div (
    .clk(clk),
    .rst_n(rst_n),
    .tickIn(selTick(outCfg_r[OUT_SRC_LSB +: 2], edges, live)),
    .enable(outCfg_r[OUT_EN_BIT]),
    .divSel(outCfg_r[OUT_DIV_LSB +: 3]),
    .tickOut(),
    .levelOut(clockOutPin)
  );
  assign sysclkTick = sysTick;

  // ================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_key_relock: assert property (
    (wrCommit && paddr == ADDR_PROTECT && pwdata[15:0] != PROTECT_UNLOCK) |=> !unlocked)
    else $error("key write did not relock");
  a_locked_system_clk: assert property (
    (wrCommit && paddr == ADDR_SYSTEM_CLK && !unlocked && !wakeApply) |=> $stable(sysCfg_r))
    else $error("locked system clock write took effect");
  a_locked_lscfg: assert property (
    (wrCommit && paddr == ADDR_LS_CFG && !unlocked) |=> $stable(lsCfg_r))
    else $error("locked config write took effect");
  a_reset_source: assert property (
    !$past(rst_n) |-> (appSrc_r == SRC_INTERNAL && sysCfg_r[SRC_LSB +: 2] == SRC_INTERNAL))
    else $error("system clock not internal after reset");
  a_int_wait: assert property (
    $rose(ready_r[OSC_INT]) |-> ($past(waitCnt_r[0]) == INT_WAIT_CYC - 17'h1)
      && flags_r[FLG_INT_STABLE])
    else $error("internal supply started without full wait");
  a_stable_flags: assert property (
    ($rose(ready_r[OSC_LS]) || $rose(ready_r[OSC_HS])) |->
      (!$rose(ready_r[OSC_LS]) || flags_r[FLG_LS_STABLE])
      && (!$rose(ready_r[OSC_HS]) || flags_r[FLG_HS_STABLE]))
    else $error("stable flag missing");
  a_sleep_stop: assert property (
    (sleepReq && oscEnReg_r[SLP_STOP_LSB + OSC_HS]) |=> !highspeedOscOn)
    else $error("source kept running in sleep");
  a_wake_apply: assert property (
    wakeApply |=> sysCfg_r[SRC_LSB +: 2] == $past(sysCfg_r[WAKE_SRC_LSB +: 2]))
    else $error("wake source not applied");
  a_clkout_off: assert property (
    !outCfg_r[OUT_EN_BIT] [*2] |-> !clockOutPin)
    else $error("clock output active while disabled");
  a_trim_done: assert property (
    trimDoneEv |=> !trimStart_r && flags_r[FLG_TRIM_DONE])
    else $error("trim completion not reported");
  a_stop_flag: assert property (
    (stopEv || $fell(oscEnReg_r[OSC_LS])) |-> ##[0:1] flags_r[FLG_LS_STOP])
    else $error("stop flag not set");
  a_irq_out: assert property (
    |(flags_r & irqEn_r) |=> clockIrq)
    else $error("interrupt request missing");
  a_switch_edge: assert property (
    $changed(appSrc_r) |-> $past(sysTick) || !$past(live[appSrc_r]))
    else $error("source switched mid-cycle");

  c_ls_ready: cover property ($rose(ready_r[OSC_LS]));
  c_stop_restart: cover property (stopEv && lsCfg_r[LS_RESTART_BIT]);
  c_trim_done: cover property (trimDoneEv);
  c_wake: cover property (wakeApply);
endmodule : ckg_clock_ctrl

// file: sim/testbench.sv
`timescale 1ns/1ps
// ================================================================
// apb register tests of the clock generator control
module testbench;
  import ckg_pkg::*;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err, lsRun;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic intClk = 1'b0, lsClk = 1'b0, hsClk = 1'b0, sleepReq, intOn, outPin, irq, seen;
  logic [2:0] supplyOn;
  logic [1:0] src, div;
  logic [3:0] divCnt = 4'h0;
  logic [5:0] trimCode;
  int error_cnt, compares, cycles;
  ckg_clock_ctrl #(.TRIM_REF_EDGES(8)) uut (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .internalClkIn(intClk), .lowspeedClkIn(lsClk), .highspeedClkIn(hsClk),
    .extClkIn(1'b0), .sleepReq(sleepReq), .internalOscOn(intOn),
    .lowspeedOscOn(), .highspeedOscOn(), .extClkOn(),
    .clockSupplyOn(supplyOn), .lowspeedCfg(), .highspeedCfg(),
    .highspeedTrim(), .internalTrimCode(trimCode), .sysclkSource(src),
    .sysclkDivider(div), .sysclkTick(), .clockOutPin(outPin), .clockIrq(irq));
  // clock and slow oscillator levels, low-speed can be stopped
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    divCnt <= divCnt + 4'h1;
    intClk <= divCnt[2];
    hsClk <= divCnt[1];
    lsClk <= lsRun & divCnt[3];
    cycles++;
    if (cycles == 60000) begin
      error_cnt++;
      $display("BAD %0t timeout", $time);
      test_done();
    end
  end
  // ================================================================
  // bus tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench timeout ends this wait
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, "read");
  endtask : rdchk
  // polls the flag register until the bit is set, bounded
  task automatic waitFlag(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, ADDR_FLAGS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 3000);
    chk({31'h0, rd[b]}, 32'h1, "flag");
  endtask : waitFlag
  task automatic lock(input logic on);
    apb(1'b1, ADDR_PROTECT, on ? 32'h0 : {16'h0, PROTECT_UNLOCK});
  endtask : lock
  task automatic test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  // ================================================================
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, sleepReq, rst_n} = '0;
    lsRun = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({30'h0, src}, {30'h0, SRC_INTERNAL}, "boot src");
    rdchk(ADDR_FLAGS, 32'h0);
    chk({31'h0, outPin}, 32'h0, "out idle");
    apb(1'b1, ADDR_SYSTEM_CLK, 32'h0000_0011);
    rdchk(ADDR_SYSTEM_CLK, SYSTEM_CLK_RST);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped");
    waitFlag(FLG_INT_STABLE);
    chk({31'h0, supplyOn[0]}, 32'h1, "supply");
    apb(1'b1, ADDR_FLAGS, 32'h1);
    rdchk(ADDR_FLAGS, 32'h0);
    lock(1'b0);
    apb(1'b1, ADDR_LS_CFG, 32'h0);
    apb(1'b1, ADDR_SYSTEM_CLK, 32'h0000_0001);
    lock(1'b1);
    apb(1'b1, ADDR_SYSTEM_CLK, 32'h0);
    rdchk(ADDR_SYSTEM_CLK, 32'h0000_0001);
    chk({30'h0, src}, 32'h1, "src");
    apb(1'b1, ADDR_ENABLES, 32'h2);
    apb(1'b1, ADDR_OSC_EN, 32'h0000_0f03);
    waitFlag(FLG_LS_STABLE);
    chk({31'h0, irq}, 32'h1, "irq");
    apb(1'b1, ADDR_FLAGS, 32'h2);
    apb(1'b1, ADDR_ENABLES, 32'h0);
    chk({31'h0, irq}, 32'h0, "irq off");
    // high-speed start while the low-speed source is already stable
    apb(1'b1, ADDR_FLAGS, 32'h4);
    lock(1'b0);
    apb(1'b1, ADDR_TRIM, 32'h0000_0015);
    apb(1'b1, ADDR_HS_CFG, 32'h0000_0001);
    lock(1'b1);
    apb(1'b1, ADDR_OSC_EN, 32'h0000_0f07);
    waitFlag(FLG_HS_STABLE);
    chk({31'h0, supplyOn[2]}, 32'h1, "hs supply");
    rdchk(ADDR_TRIM, 32'h0000_0015);
    lock(1'b0);
    apb(1'b1, ADDR_IOSC_CTL, 32'h1);
    waitFlag(FLG_TRIM_DONE);
    rdchk(ADDR_IOSC_CTL, 32'h0);
    // 8 reference edges span 14 to 16 internal edges
    chk({31'h0, trimCode >= 6'h18 && trimCode <= 6'h1a}, 32'h1, "trim code");
    apb(1'b1, ADDR_CLKOUT, 32'h0000_0001);
    seen = 1'b0;
    repeat (64) begin
      @(posedge clk);
      seen = seen | outPin;
    end
    chk({31'h0, seen}, 32'h1, "out runs");
    apb(1'b1, ADDR_CLKOUT, 32'h0);
    @(posedge clk);
    chk({31'h0, outPin}, 32'h0, "out off");
    apb(1'b1, ADDR_LS_CFG, 32'h0300_0000);
    lock(1'b1);
    apb(1'b1, ADDR_LS_CFG, 32'h0);
    rdchk(ADDR_LS_CFG, 32'h0300_0000);
    lsRun <= 1'b0;
    waitFlag(FLG_LS_STOP);
    lsRun <= 1'b1;
    apb(1'b1, ADDR_FLAGS, 32'h20);
    rdchk(ADDR_FLAGS, 32'h14);
    lock(1'b0);
    apb(1'b1, ADDR_LS_CFG, 32'h0);
    waitFlag(FLG_LS_STOP);
    apb(1'b1, ADDR_SYSTEM_CLK, 32'h0000_9001);
    chk({31'h0, intOn}, 32'h1, "run");
    sleepReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk({31'h0, intOn}, 32'h0, "sleep");
    sleepReq <= 1'b0;
    repeat (4) @(posedge clk);
    rdchk(ADDR_SYSTEM_CLK, 32'h0000_9010);
    chk({30'h0, div}, 32'h1, "wake div");
    test_done();
  end
endmodule : testbench
